// ### verilog/clock_sources.sv
// Purpose: clock source control, low-speed clocks and two wake timers
// Assumes: 200 MHz clk; low-speed oscillator modelled by an enable divider
// Notes: all slow clocks are one-cycle enable pulses on clk
//
// Contract
// [RQ1] 13-bit central timer advanced by 1 kHz
// [RQ2] central timer stops in hibernate or debug halt
// [RQ3] software can clear the central timer
// [RQ4] central timer gives periodic wakes, optional interrupt
// [RQ5] 5-bit fast timer advanced by 100 kHz
// [RQ6] fast timer wraps at programmable terminal count
// [RQ7] fast timer terminal count may raise interrupt
// [RQ8] low-speed logic makes 1, 33, 100 kHz
// [RQ9] 33 kHz is 100 kHz divided by three
// [RQ10] multiplier locks within 250 us, lock bit
// [RQ11] lock indication can raise an interrupt
// [RQ12] multiplier input from main, crystal or interconnect
// [RQ13] input and feedback dividers set multiplier ratio
// [RQ14] doubler doubles a selected 6..24 MHz input
// [RQ15] main oscillator offers 3..74 MHz steps
// [RQ16] software disables multiplier before low power
// [RQ17] fast terminal count applies from next wrap
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module clock_sources
#(
    parameter int LOCK_TIME = clock_pkg::LOCK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire clock_pkg::reg_req_t bus_req,
    output logic [31:0] rd_data,
    input wire logic hibernate,
    input wire logic debug_halt,
    output clock_pkg::clk_cfg_t clk_cfg,
    output logic fast_lowspeed_clk,
    output logic third_lowspeed_clk,
    output logic slow_tick_clk,
    output logic ctw_wake,
    output logic ftw_wake,
    output logic pll_lock,
    output logic irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] ls_div; // cycles per fast tick
    logic [1:0] third_div; // 100 kHz ticks per 33 kHz tick
    logic [6:0] slow_div; // 100 kHz ticks per 1 kHz tick
    logic fast_tick; // combinational 100 kHz enable
    logic [1:0] hib_sync; // hibernate synchroniser
    logic [1:0] dbg_sync; // debug halt synchroniser
    logic ctw_hold; // central timer frozen
    logic [12:0] ctw_count; // central timer count
    logic [12:0] next_ctw_count;
    logic [3:0] ctw_tap; // wake period is 2^tap ms, 2^13 ms for any tap above 13
    logic [12:0] tap_mask;
    logic ctw_clear; // software clear request
    logic ftw_en; // fast timer running
    logic [4:0] ftw_count; // fast timer count
    logic [4:0] ftw_term; // terminal count in use
    logic [4:0] ftw_shadow; // terminal count as written
    logic ctw_event; // central timer wake, this cycle
    logic ftw_event; // fast timer wrap, this cycle
    logic lock_event; // multiplier just locked
    logic [2:0] status; // sticky events
    logic [2:0] mask; // interrupt enables
    logic [2:0] event_vec;
    clock_pkg::pll_state_t pll_state;
    logic [31:0] lock_cnt; // cycles spent waiting for lock
    logic wr_hit;
    logic [31:0] wd;

    assign wd = bus_req.wdata;
    assign wr_hit = bus_req.wr;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // power pins are asynchronous
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hib_sync <= 2'h0;
            dbg_sync <= 2'h0;
        end
        else
        begin
            hib_sync <= {hib_sync[0], hibernate};
            dbg_sync <= {dbg_sync[0], debug_halt};
        end
    end

    // only the second stage is read
    assign ctw_hold = hib_sync[1] | dbg_sync[1]; // [RQ2]

    // ------------------------------------------------------------
    // low-speed oscillator clocks
    // ------------------------------------------------------------
    // 100 kHz base from the system clock
    assign fast_tick = (ls_div == 16'(clock_pkg::FAST_DIV - 1));

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ls_div <= 16'h0000;
        end
        else if (fast_tick)
        begin
            ls_div <= 16'h0000;
        end
        else
        begin
            ls_div <= ls_div + 16'h0001;
        end
    end

    // derived ticks, registered one cycle after fast_tick
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            third_div <= 2'h0;
            slow_div <= 7'h00;
            fast_lowspeed_clk <= 1'b0;
            third_lowspeed_clk <= 1'b0;
            slow_tick_clk <= 1'b0;
        end
        else
        begin
            fast_lowspeed_clk <= fast_tick; // [RQ8]
            third_lowspeed_clk <= 1'b0;
            slow_tick_clk <= 1'b0;
            if (fast_tick)
            begin
                // divide by three for the 33 kHz output
                if (third_div == 2'(clock_pkg::THIRD_DIV - 1))
                begin
                    third_div <= 2'h0;
                    third_lowspeed_clk <= 1'b1; // [RQ9]
                end
                else
                begin
                    third_div <= third_div + 2'h1;
                end
                // divide by one hundred for the 1 kHz output
                if (slow_div == 7'(clock_pkg::SLOW_DIV - 1))
                begin
                    slow_div <= 7'h00;
                    slow_tick_clk <= 1'b1; // [RQ8]
                end
                else
                begin
                    slow_div <= slow_div + 7'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // central wake timer
    // ------------------------------------------------------------
    // free running; tap picks a 2^n wake period
    assign next_ctw_count = ctw_count + 13'h0001;
    assign tap_mask = 13'((14'h0001 << ctw_tap) - 14'h0001);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctw_count <= 13'h0000;
            ctw_event <= 1'b0;
        end
        else
        begin
            ctw_event <= 1'b0;
            if (ctw_clear)
            begin
                // clear beats a same-cycle tick
                ctw_count <= 13'h0000; // [RQ3]
            end
            else if (slow_tick_clk && !ctw_hold) // [RQ2]
            begin
                ctw_count <= next_ctw_count; // [RQ1]
                ctw_event <= ((next_ctw_count & tap_mask) == 13'h0000); // [RQ4]
            end
        end
    end

    assign ctw_wake = ctw_event; // [RQ4]

    // ------------------------------------------------------------
    // fast wake timer
    // ------------------------------------------------------------
    // new terminal taken only at wrap or while stopped,
    // so a running period is never cut or stretched
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ftw_count <= 5'h00;
            ftw_term <= clock_pkg::RST_FTW_TERM;
            ftw_event <= 1'b0;
        end
        else
        begin
            ftw_event <= 1'b0;
            if (!ftw_en)
            begin
                // stopped: restart with newest setting
                ftw_count <= 5'h00;
                ftw_term <= ftw_shadow;
            end
            else if (fast_lowspeed_clk) // [RQ5]
            begin
                if (ftw_count == ftw_term) // [RQ6]
                begin
                    ftw_count <= 5'h00;
                    ftw_term <= ftw_shadow; // [RQ17]
                    ftw_event <= 1'b1; // [RQ7]
                end
                else
                begin
                    ftw_count <= ftw_count + 5'h01; // [RQ5]
                end
            end
        end
    end

    assign ftw_wake = ftw_event;

    // ------------------------------------------------------------
    // multiplier lock tracking
    // ------------------------------------------------------------
    // lock after the worst-case settle time;
    // disable drops lock at once
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pll_state <= clock_pkg::PLL_OFF;
            lock_cnt <= 32'h00000000;
            lock_event <= 1'b0;
        end
        else
        begin
            lock_event <= 1'b0;
            case (pll_state)
                clock_pkg::PLL_OFF:
                begin
                    lock_cnt <= 32'h00000000;
                    if (clk_cfg.pll_en)
                    begin
                        pll_state <= clock_pkg::PLL_WAIT;
                    end
                end
                clock_pkg::PLL_WAIT:
                begin
                    if (!clk_cfg.pll_en)
                    begin
                        pll_state <= clock_pkg::PLL_OFF; // [RQ16]
                    end
                    else if (lock_cnt == 32'(LOCK_TIME - 1))
                    begin
                        pll_state <= clock_pkg::PLL_LOCKED; // [RQ10]
                        lock_event <= 1'b1; // [RQ11]
                    end
                    else
                    begin
                        lock_cnt <= lock_cnt + 32'h00000001;
                    end
                end
                clock_pkg::PLL_LOCKED:
                begin
                    if (!clk_cfg.pll_en)
                    begin
                        pll_state <= clock_pkg::PLL_OFF;
                    end
                end
                default:
                begin
                    pll_state <= clock_pkg::PLL_OFF;
                end
            endcase
        end
    end

    assign pll_lock = (pll_state == clock_pkg::PLL_LOCKED); // [RQ10]

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // reserved source code refused; mux never sees it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clk_cfg.pll_en <= 1'b0;
            clk_cfg.pll_src <= clock_pkg::SRC_MAIN;
            clk_cfg.pll_in_div <= clock_pkg::RST_IN_DIV;
            clk_cfg.pll_fb_div <= clock_pkg::RST_FB_DIV;
            clk_cfg.dbl_en <= 1'b0;
            clk_cfg.dbl_src <= clock_pkg::SRC_MAIN;
            clk_cfg.main_sel <= clock_pkg::MAIN_3;
            ftw_en <= 1'b0;
            ftw_shadow <= clock_pkg::RST_FTW_TERM;
            ctw_tap <= clock_pkg::RST_CTW_TAP;
            ctw_clear <= 1'b0;
        end
        else
        begin
            ctw_clear <= 1'b0;
            if (wr_hit && bus_req.addr == clock_pkg::OFS_CTRL)
            begin
                ftw_en <= wd[clock_pkg::CTRL_FTW_EN];
                clk_cfg.pll_en <= wd[clock_pkg::CTRL_PLL_EN];
                ctw_clear <= wd[clock_pkg::CTRL_CTW_CLR]; // [RQ3]
                clk_cfg.dbl_en <= wd[clock_pkg::CTRL_DBL_EN]; // [RQ14]
                if (wd[clock_pkg::CTRL_PLL_SRC+1 -: 2] != 2'h3)
                begin
                    clk_cfg.pll_src <= clock_pkg::src_sel_t'(
                        wd[clock_pkg::CTRL_PLL_SRC+1 -: 2]); // [RQ12]
                end
                if (wd[clock_pkg::CTRL_DBL_SRC+1 -: 2] != 2'h3)
                begin
                    clk_cfg.dbl_src <= clock_pkg::src_sel_t'(
                        wd[clock_pkg::CTRL_DBL_SRC+1 -: 2]); // [RQ14]
                end
                // only the six frequency steps taken
                if (wd[clock_pkg::CTRL_MAIN_SEL+2 -: 3] <= 3'h5)
                begin
                    clk_cfg.main_sel <= clock_pkg::main_sel_t'(
                        wd[clock_pkg::CTRL_MAIN_SEL+2 -: 3]); // [RQ15]
                end
            end
            if (wr_hit && bus_req.addr == clock_pkg::OFS_CTW_TAP)
            begin
                ctw_tap <= wd[3:0]; // [RQ4]
            end
            if (wr_hit && bus_req.addr == clock_pkg::OFS_FTW_TERM)
            begin
                ftw_shadow <= wd[4:0]; // [RQ17]
            end
            if (wr_hit && bus_req.addr == clock_pkg::OFS_PLL_DIV)
            begin
                clk_cfg.pll_in_div <= wd[5:0]; // [RQ13]
                clk_cfg.pll_fb_div <= wd[clock_pkg::PLL_FB_POS+7 -: 8]; // [RQ13]
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    assign event_vec = {lock_event, ftw_event, ctw_event};

    // write one clears; a same-cycle event wins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status <= 3'h0;
            mask <= 3'h0;
        end
        else
        begin
            if (wr_hit && bus_req.addr == clock_pkg::OFS_STATUS)
            begin
                status <= (status & ~wd[2:0]) | event_vec; // [RQ7]
            end
            else
            begin
                status <= status | event_vec; // [RQ11]
            end
            if (wr_hit && bus_req.addr == clock_pkg::OFS_MASK)
            begin
                mask <= wd[2:0];
            end
        end
    end

    assign irq = |(status & mask); // [RQ4]

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // data one cycle after the strobe; unmapped reads 0
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data <= 32'h00000000;
        end
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                clock_pkg::OFS_CTRL:
                    rd_data <= {20'h00000, clk_cfg.main_sel, clk_cfg.dbl_en,
                        clk_cfg.dbl_src, clk_cfg.pll_src, 1'b0, 1'b0,
                        clk_cfg.pll_en, ftw_en};
                clock_pkg::OFS_CTW_COUNT:
                    rd_data <= {19'h00000, ctw_count};
                clock_pkg::OFS_CTW_TAP:
                    rd_data <= {28'h0000000, ctw_tap};
                clock_pkg::OFS_FTW_TERM:
                    rd_data <= {27'h0000000, ftw_shadow};
                clock_pkg::OFS_PLL_DIV:
                    rd_data <= {16'h0000, clk_cfg.pll_fb_div, 2'h0,
                        clk_cfg.pll_in_div};
                clock_pkg::OFS_STATUS:
                    rd_data <= {29'h00000000, status};
                clock_pkg::OFS_MASK:
                    rd_data <= {29'h00000000, mask};
                clock_pkg::OFS_STATE:
                    rd_data <= {19'h00000, ftw_count, 7'h00, pll_lock}; // [RQ10]
                default:
                    rd_data <= 32'h00000000;
            endcase
        end
        else
        begin
            rd_data <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// ### verilog/clock_pkg.sv
// Purpose: shared constants and carriers for the clock source block
// Assumes: 200 MHz system clock, one clock domain
// Notes: register offsets are byte addresses on a 32-bit word port
package clock_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200000000;
    localparam int FAST_LS_HZ = 100000;
    localparam int FAST_DIV = CLK_HZ / FAST_LS_HZ;
    localparam int THIRD_DIV = 3;
    localparam int SLOW_DIV = 100;
    localparam int LOCK_US = 250;
    localparam int LOCK_CYCLES = LOCK_US * (CLK_HZ / 1000000);

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CTW_COUNT = 8'h04;
    localparam logic [7:0] OFS_CTW_TAP = 8'h08;
    localparam logic [7:0] OFS_FTW_TERM = 8'h0C;
    localparam logic [7:0] OFS_PLL_DIV = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_STATE = 8'h1C;

    // ------------------------------------------------------------
    // field positions of the control and divider registers
    // ------------------------------------------------------------
    localparam int CTRL_FTW_EN = 0;
    localparam int CTRL_PLL_EN = 1;
    localparam int CTRL_CTW_CLR = 2;
    localparam int CTRL_PLL_SRC = 4;
    localparam int CTRL_DBL_SRC = 6;
    localparam int CTRL_DBL_EN = 8;
    localparam int CTRL_MAIN_SEL = 9;
    localparam int PLL_FB_POS = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_CTW_TAP = 4'hA;
    localparam logic [4:0] RST_FTW_TERM = 5'h1F;
    localparam logic [5:0] RST_IN_DIV = 6'h01;
    localparam logic [7:0] RST_FB_DIV = 8'h08;

    // multiplier and doubler source
    typedef enum logic [1:0] {
        SRC_MAIN = 2'b00,
        SRC_XTAL = 2'b01,
        SRC_DSI = 2'b10
    } src_sel_t;

    // main oscillator frequency steps 3..74 MHz
    typedef enum logic [2:0] {
        MAIN_3 = 3'b000,
        MAIN_6 = 3'b001,
        MAIN_12 = 3'b010,
        MAIN_24 = 3'b011,
        MAIN_48 = 3'b100,
        MAIN_74 = 3'b101
    } main_sel_t;

    // multiplier loop lock tracking
    typedef enum logic [1:0] {
        PLL_OFF = 2'b00,
        PLL_WAIT = 2'b01,
        PLL_LOCKED = 2'b10
    } pll_state_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // analog clock source configuration
    typedef struct packed {
        logic pll_en;
        src_sel_t pll_src;
        logic [5:0] pll_in_div;
        logic [7:0] pll_fb_div;
        logic dbl_en;
        src_sel_t dbl_src;
        main_sel_t main_sel;
    } clk_cfg_t;

endpackage

// ### verification/clock_sources_checker.sv
// Purpose: port assertions for the clock block
// Assumes: bound to clock_sources, one clock domain
// Notes: 1 kHz checks fire only in long runs
`timescale 1ns/10ps
`default_nettype none

module clock_sources_checker
#(
    parameter int LOCK_TIME = 20
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire clock_pkg::clk_cfg_t clk_cfg,
    input wire logic fast_lowspeed_clk,
    input wire logic third_lowspeed_clk,
    input wire logic slow_tick_clk,
    input wire logic ctw_wake,
    input wire logic ftw_wake,
    input wire logic pll_lock,
    input wire logic irq
);
    logic [11:0] gap; // cycles since fast pulse
    logic gap_ok; // a fast pulse was seen
    logic [1:0] fcnt; // fast pulses since third pulse
    logic third_ok; // a third pulse was seen
    logic [31:0] lcnt; // cycles with the loop enabled

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gap <= 12'h000;
            gap_ok <= 1'b0;
            fcnt <= 2'h0;
            third_ok <= 1'b0;
            lcnt <= 32'h0;
        end
        else
        begin
            gap <= fast_lowspeed_clk ? 12'h000 : gap + 12'h001;
            gap_ok <= gap_ok | fast_lowspeed_clk;
            fcnt <= third_lowspeed_clk ? 2'h0 : fcnt + {1'b0, fast_lowspeed_clk};
            third_ok <= third_ok | third_lowspeed_clk;
            lcnt <= clk_cfg.pll_en ? lcnt + 32'h1 : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_fast_gap_2000: assert property (fast_lowspeed_clk && gap_ok |-> gap == 12'h7CF)
        else $error("fast period wrong");
    a_third_every_three: assert property (third_lowspeed_clk && third_ok |-> fcnt == 2'h2)
        else $error("third ratio wrong");
    a_third_on_fast: assert property (third_lowspeed_clk |-> fast_lowspeed_clk)
        else $error("third off fast");
    a_slow_on_fast: assert property (slow_tick_clk |-> fast_lowspeed_clk)
        else $error("slow off fast");
    a_ftw_after_tick: assert property (ftw_wake |-> $past(fast_lowspeed_clk))
        else $error("fast wake untimed");
    a_ctw_after_tick: assert property (ctw_wake |-> $past(slow_tick_clk))
        else $error("central wake untimed");
    a_ftw_wake_single: assert property (ftw_wake |=> !ftw_wake)
        else $error("fast wake too long");
    a_ctw_wake_single: assert property (ctw_wake |=> !ctw_wake [*8])
        else $error("central wake too soon");
    a_lock_time_exact: assert property ($rose(pll_lock) |-> lcnt == LOCK_TIME + 1)
        else $error("lock time wrong");
    a_lock_drop_off: assert property (!clk_cfg.pll_en |=> !pll_lock)
        else $error("lock after disable");

    c_lock: cover property ($rose(pll_lock));
    c_ftw: cover property (ftw_wake);
    c_irq: cover property ($rose(irq));
    c_third: cover property (third_lowspeed_clk);
endmodule

bind clock_sources clock_sources_checker #(.LOCK_TIME(LOCK_TIME)) i_chk (
    .clk(clk),
    .rst_b(rst_b),
    .clk_cfg(clk_cfg),
    .fast_lowspeed_clk(fast_lowspeed_clk),
    .third_lowspeed_clk(third_lowspeed_clk),
    .slow_tick_clk(slow_tick_clk),
    .ctw_wake(ctw_wake),
    .ftw_wake(ftw_wake),
    .pll_lock(pll_lock),
    .irq(irq)
);

`default_nettype wire

// ### verification/clock_sources_and_timewheels_test.sv
// Purpose: bench for the clock block
// Assumes: 200 MHz clk, short lock time
// Notes: reads and wake periods checked from queues
`timescale 1ns/10ps
`default_nettype none

module clock_sources_and_timewheels_test;
    localparam int LT = 20; // short lock time keeps the run brief
    logic clk;
    logic rst_b;
    clock_pkg::reg_req_t req;
    logic [31:0] rd_data;
    logic hibernate;
    logic debug_halt;
    clock_pkg::clk_cfg_t cfg;
    logic fast;
    logic third;
    logic slow;
    logic ctw_wake;
    logic ftw_wake;
    logic pll_lock;
    logic irq;
    int err_count;
    int tests_run;
    int cyc; // run length guard
    int gap; // fast wake gap
    logic rd_seen; // read last edge
    logic [31:0] rd_q[$]; // expected read data
    logic [31:0] per_q[$]; // expected wake periods
    logic [4:0] t1, t2;
    logic [31:0] dv;

    clock_sources #(.LOCK_TIME(LT)) i_dut (
        .clk(clk),
        .rst_b(rst_b),
        .bus_req(req),
        .rd_data(rd_data),
        .hibernate(hibernate),
        .debug_halt(debug_halt),
        .clk_cfg(cfg),
        .fast_lowspeed_clk(fast),
        .third_lowspeed_clk(third),
        .slow_tick_clk(slow),
        .ctw_wake(ctw_wake),
        .ftw_wake(ftw_wake),
        .pll_lock(pll_lock),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one strobe cycle, then a cycle with the strobes low
    task automatic bus(logic r, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: !r, rd: r};
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask

    // bounded wait; returns after the wake so a new note misses it
    task automatic wait_ftw();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (ftw_wake !== 1'b1 && n < 20000);
        chk("ftw_wake", 1, ftw_wake);
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // monitors: read data, wake periods, run guard
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        rd_seen <= req.rd;
        if (rd_seen)
            chk("rd_data", rd_q.pop_front(), rd_data);
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        gap <= ftw_wake ? 1 : gap + 1;
        if (ftw_wake && per_q.size() > 0)
            chk("ftw_period", per_q.pop_front(), gap);
        if (cyc == 80000)
        begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        req = '0;
        hibernate = 1'b0;
        debug_halt = 1'b0;
        rst_b = 1'b0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        gap = 0;
        rd_seen = 1'b0;
        void'($urandom(50));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(clock_pkg::OFS_CTW_TAP, 32'h0000000A);
        rd(clock_pkg::OFS_FTW_TERM, 32'h0000001F);
        rd(clock_pkg::OFS_PLL_DIV, 32'h00000801);
        rd(clock_pkg::OFS_MASK, 32'h00000000);
        bus(1'b0, 8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h00000000);
        // all steps and sources
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, clock_pkg::OFS_CTRL, (i << 9) | ((i % 3) << 6) | ((i % 3) << 4));
            @(negedge clk);
            chk("main_sel", i, cfg.main_sel);
            chk("pll_src", i % 3, cfg.pll_src);
            chk("dbl_src", i % 3, cfg.dbl_src);
        end
        // refused codes keep fields; clear reads 0
        bus(1'b0, clock_pkg::OFS_CTRL, 32'h00000F34);
        rd(clock_pkg::OFS_CTRL, 32'h00000B20);
        chk("dbl_en", 1, cfg.dbl_en);
        dv = $urandom & 32'h0000FF3F;
        bus(1'b0, clock_pkg::OFS_PLL_DIV, dv);
        rd(clock_pkg::OFS_PLL_DIV, dv);
        chk("in_div", dv[5:0], cfg.pll_in_div);
        // lock, status and irq
        bus(1'b0, clock_pkg::OFS_MASK, 32'h00000006);
        bus(1'b0, clock_pkg::OFS_CTRL, 32'h00000002);
        for (int n = 0; n < 100 && pll_lock !== 1'b1; n++)
            @(negedge clk);
        chk("pll_lock", 1, pll_lock);
        repeat (2) @(negedge clk);
        chk("irq", 1, irq);
        rd(clock_pkg::OFS_STATUS, 32'h00000004);
        rd(clock_pkg::OFS_STATE, 32'h00000001);
        bus(1'b0, clock_pkg::OFS_STATUS, 32'h00000004);
        @(negedge clk);
        chk("irq", 0, irq);
        bus(1'b0, clock_pkg::OFS_CTRL, 32'h00000000);
        repeat (2) @(negedge clk);
        chk("pll_lock", 0, pll_lock);
        // clear while halted, tap
        hibernate <= 1'b1;
        debug_halt <= 1'b1;
        bus(1'b0, clock_pkg::OFS_CTRL, 32'h00000004);
        bus(1'b0, clock_pkg::OFS_CTW_TAP, 32'h00000000);
        rd(clock_pkg::OFS_CTW_COUNT, 32'h00000000);
        rd(clock_pkg::OFS_CTW_TAP, 32'h00000000);
        hibernate <= 1'b0;
        debug_halt <= 1'b0;
        // fast periods, terminal change
        t1 = $urandom_range(3, 1);
        t2 = $urandom_range(2, 0);
        bus(1'b0, clock_pkg::OFS_FTW_TERM, t1);
        bus(1'b0, clock_pkg::OFS_CTRL, 32'h00000001);
        wait_ftw();
        per_q.push_back((t1 + 1) * 2000);
        wait_ftw();
        bus(1'b0, clock_pkg::OFS_FTW_TERM, t2);
        per_q.push_back((t1 + 1) * 2000);
        per_q.push_back((t2 + 1) * 2000);
        wait_ftw();
        repeat (2) @(negedge clk);
        chk("irq", 1, irq);
        rd(clock_pkg::OFS_STATUS, 32'h00000002);
        bus(1'b0, clock_pkg::OFS_MASK, 32'h00000000);
        @(negedge clk);
        chk("irq", 0, irq);
        wait_ftw();
        bus(1'b0, clock_pkg::OFS_STATUS, 32'h00000002);
        rd(clock_pkg::OFS_STATUS, 32'h00000000);
        bus(1'b0, clock_pkg::OFS_CTRL, 32'h00000000);
        chk("queue", 0, per_q.size());
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule

`default_nettype wire
